// ===== dv/smc_far.sv
// smc_far: far side of both serial buses and the controller engine events
// assumes pull-ups on the lines, so a released line reads high
module smc_far (
  // clock
  input  wire logic       clk,
  // line levels: target clock, target data, controller clock, controller data
  output logic      [3:0] ln,
  // events: lost, won, check, bad, timeout
  output logic      [4:0] evt
);
  timeunit 1ns;
  timeprecision 1ps;

  initial ln = 4'hF;
  initial evt = 5'h00;

  task hold(input logic lv);
    @(posedge clk);
    ln <= {4{lv}};
  endtask : hold

  // one-cycle pulse, as the engines give them
  task pulse(input logic [4:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 5'h00;
  endtask : pulse
endmodule : smc_far

// ===== dv/test_smbus_timing_mode_control.sv
// test_smbus_timing_mode_control: self-checking bench for smc_ctrl
// assumes smc_pkg and the partner model smc_far are compiled first
module test_smbus_timing_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;
  localparam int          FC = 4;
  localparam logic [11:0] CT = SMC_CTRL_ADDR;
  localparam logic [11:0] ST = SMC_STAT_ADDR;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, tick, pclk, retry, abort, tev;
  logic [3:0]  ln, flt;
  logic [4:0]  evt;
  logic [33:0] q[$];
  logic [33:0] x;
  logic [15:0] seed = 16'h0002;
  logic [15:0] d;
  int          bad_count = 0;
  int          comparisons = 0;
  int          i, g, n, m, lo;

  always #12.5 CLOCK = ~CLOCK;

  smc_ctrl #(.FAST_CYC(FC)) DUT (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TGT_SCL_IN(ln[3]), .TGT_SDA_IN(ln[2]), .CTL_SCL_IN(ln[1]), .CTL_SDA_IN(ln[0]),
    .ARB_LOST(evt[4]), .ARB_WON(evt[3]), .CS_CHECK(evt[2]), .CS_BAD(evt[1]), .TIMEOUT_RAW(evt[0]),
    .TGT_SCL_F(flt[3]), .TGT_SDA_F(flt[2]), .CTL_SCL_F(flt[1]), .CTL_SDA_F(flt[0]),
    .PRESCALE_TICK(tick), .PRESCALE_CLK(pclk), .ARB_RETRY(retry), .XFER_ABORT(abort), .TIMEOUT_EVT(tev)
  );
  smc_far p (.clk(CLOCK), .ln(ln), .evt(evt));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task results;
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // expectation queued before the access; the monitor checks it at pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
    int k;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    q.push_back({w, e});
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      results;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] wd, input logic err);
    apb(1'b1, a, wd, {err, 32'h0});
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0, {err, e});
  endtask : rd

  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      x = q.pop_front();
      chk({31'h0, PSLVERR}, {31'h0, x[32]});
      if (!x[33]) chk(PRDATA, x[31:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    rd(CT, 32'h0000_0053, 1'b0);
    rd(ST, 32'h0, 1'b0);
    rd(12'h42C, 32'h0, 1'b1);
    wr(12'h42C, 32'hFFFF_FFFF, 1'b1);
    wr(CT, 32'hFFFF_FFFF, 1'b0);
    rd(CT, 32'h0043_FFFF, 1'b0);
    // divider 0 and 1 first, then random periods
    for (i = 0; i < 5; i++) begin
      d = i < 2 ? 16'(i) : (rnd() % 16'd60) + 16'd2;
      wr(CT, {16'h0, d}, 1'b0);
      repeat (3) @(posedge CLOCK);
      n = 0;
      do begin
        @(posedge CLOCK);
        n++;
      end while (tick !== 1'b1 && n < 300);
      if (i < 2) chk(32'(n), 32'd300);
      else begin
        m = 0;
        lo = 0;
        do begin
          @(posedge CLOCK);
          m++;
          lo += (pclk === 1'b0);
        end while (tick !== 1'b1 && m < 300);
        chk(32'(m), 32'(d) * SMC_UNIT_CYC);
        chk(32'(lo), SMC_UNIT_CYC * ((32'(d) + 1) / 2));
      end
    end
    // ignore-masters first, so the loss count starts clean afterwards
    for (g = 1; g >= 0; g--) begin
      wr(CT, {15'h0, g[0], 16'h0053}, 1'b0);
      for (i = 1; i <= 16; i++) begin
        p.pulse(5'h10);
        @(posedge CLOCK);
        chk({retry, abort}, g ? 32'h0 : {i < 16, i == 16});
      end
      rd(ST, g ? 32'h0 : 32'h0400_0000, 1'b0);
      wr(ST, 32'h0400_0000, 1'b0);
    end
    for (g = 1; g >= 0; g--) begin
      wr(CT, {9'h0, g[0], 4'h0, g[0], 1'b0, 16'h0053}, 1'b0);
      p.pulse(5'h06);
      p.pulse(5'h01);
      @(posedge CLOCK);
      chk({31'h0, tev}, {31'h0, !g[0]});
      rd(ST, g ? 32'h0 : 32'h1000_0000, 1'b0);
      wr(ST, 32'h1000_0000, 1'b0);
      rd(ST, 32'h0, 1'b0);
    end
    // each filter mode, both edges of all four lines
    for (g = 0; g < 3; g++) begin
      m = g == 0 ? 40 : (g == 1 ? FC : 1);
      wr(CT, {10'h0, g[1:0], g[1:0], 2'h0, 16'h0053}, 1'b0);
      for (i = 0; i < 2; i++) begin
        p.hold(i[0]);
        n = 0;
        do begin
          @(posedge CLOCK);
          n++;
        end while (flt !== {4{i[0]}} && n < 100);
        chk({31'h0, n >= m && n <= m + 2}, 32'h1);
      end
    end
    results;
  end
endmodule : test_smbus_timing_mode_control

// ===== hw/smc_ctrl.sv
// smc_ctrl: control register and sideband behaviour of the two serial ports
// assumes an APB master on the core clock; pins are synchronous inputs
//
// Local design decision: the APB register port.
module smc_ctrl #(
  parameter int FAST_CYC = smc_pkg::SMC_FAST_CYC
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial pins, raw levels
  input  wire logic        TGT_SCL_IN,
  input  wire logic        TGT_SDA_IN,
  input  wire logic        CTL_SCL_IN,
  input  wire logic        CTL_SDA_IN,
  // controller engine events
  input  wire logic        ARB_LOST,
  input  wire logic        ARB_WON,
  input  wire logic        CS_CHECK,
  input  wire logic        CS_BAD,
  input  wire logic        TIMEOUT_RAW,
  // outputs to the port engines
  output logic             TGT_SCL_F,
  output logic             TGT_SDA_F,
  output logic             CTL_SCL_F,
  output logic             CTL_SDA_F,
  output logic             PRESCALE_TICK,
  output logic             PRESCALE_CLK,
  output logic             ARB_RETRY,
  output logic             XFER_ABORT,
  output logic             TIMEOUT_EVT
);
  import smc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] div_r;
  logic        ignm_r;
  logic        skipcs_r;
  logic [1:0]  tfs_r;
  logic [1:0]  cfs_r;
  logic        toinh_r;
  logic        arbf_r;
  logic        csf_r;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        hit;
  logic [15:0] div_in;
  logic [1:0]  tfs_in;
  logic [1:0]  cfs_in;

  assign acc     = PSEL && PENABLE;
  assign hit     = (PADDR == SMC_CTRL_ADDR) || (PADDR == SMC_STAT_ADDR);
  assign wr_ctrl = acc && PWRITE && PADDR == SMC_CTRL_ADDR;
  assign wr_stat = acc && PWRITE && PADDR == SMC_STAT_ADDR;
  assign div_in  = PWDATA[SMC_DIV_LSB +: SMC_DIV_W];
  assign tfs_in  = PWDATA[SMC_TFS_LSB +: 2];
  assign cfs_in  = PWDATA[SMC_CFS_LSB +: 2];

  function automatic logic [1:0] fs_clean(input logic [1:0] v);
    // reserved selection falls back to normal filtering
    fs_clean = (v == 2'h3) ? SMC_FS_NORMAL : v;
  endfunction : fs_clean

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      div_r    <= SMC_DIV_RST;
      ignm_r   <= 1'b0;
      skipcs_r <= 1'b0;
      tfs_r    <= SMC_FS_RST;
      cfs_r    <= SMC_FS_RST;
      toinh_r  <= 1'b0;
    end else if (wr_ctrl) begin
      div_r    <= div_in;
      ignm_r   <= PWDATA[SMC_IGNM_BIT];
      skipcs_r <= PWDATA[SMC_SKIPCS_BIT];
      tfs_r    <= fs_clean(tfs_in);
      cfs_r    <= fs_clean(cfs_in);
      toinh_r  <= PWDATA[SMC_TOINH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read words, built from the field positions
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  always_comb begin
    ctrl_word                           = 32'h0000_0000;
    ctrl_word[SMC_DIV_LSB +: SMC_DIV_W] = div_r;
    ctrl_word[SMC_IGNM_BIT]             = ignm_r;
    ctrl_word[SMC_SKIPCS_BIT]           = skipcs_r;
    ctrl_word[SMC_TFS_LSB +: 2]         = tfs_r;
    ctrl_word[SMC_CFS_LSB +: 2]         = cfs_r;
    ctrl_word[SMC_TOINH_BIT]            = toinh_r;
  end

  // status bits other than the two flags read as zero
  always_comb begin
    stat_word               = 32'h0000_0000;
    stat_word[SMC_ARBF_BIT] = arbf_r;
    stat_word[SMC_CSF_BIT]  = csf_r;
  end

  // single-cycle access phase, errors on unmapped address
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE) begin
        if (PADDR == SMC_CTRL_ADDR)
          PRDATA <= ctrl_word;
        else if (PADDR == SMC_STAT_ADDR)
          PRDATA <= stat_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // glitch filters
  smc_glitch #(
    .NORM_CYC (SMC_GLITCH_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_tscl (
    .clk  (CLOCK),
    .rst  (RST),
    .sel  (tfs_r),
    .din  (TGT_SCL_IN),
    .dout (TGT_SCL_F)
  );

  smc_glitch #(
    .NORM_CYC (SMC_GLITCH_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_tsda (
    .clk  (CLOCK),
    .rst  (RST),
    .sel  (tfs_r),
    .din  (TGT_SDA_IN),
    .dout (TGT_SDA_F)
  );

  smc_glitch #(
    .NORM_CYC (SMC_GLITCH_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_cscl (
    .clk  (CLOCK),
    .rst  (RST),
    .sel  (cfs_r),
    .din  (CTL_SCL_IN),
    .dout (CTL_SCL_F)
  );

  smc_glitch #(
    .NORM_CYC (SMC_GLITCH_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_csda (
    .clk  (CLOCK),
    .rst  (RST),
    .sel  (cfs_r),
    .din  (CTL_SDA_IN),
    .dout (CTL_SDA_F)
  );

  ////////////////////////////////////////////////////////////////////////////
  // prescaler
  smc_prescale #(.UNIT_CYC(SMC_UNIT_CYC)) u_pre (
    .clk  (CLOCK),
    .rst  (RST),
    .div  (div_r),
    .tick (PRESCALE_TICK),
    .pclk (PRESCALE_CLK)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arbitration tracking
  logic [4:0] loss_r;
  logic       limit;

  assign limit = (loss_r == 5'(SMC_ARB_LIMIT - 1));

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      loss_r     <= 5'h00;
      ARB_RETRY  <= 1'b0;
      XFER_ABORT <= 1'b0;
    end else begin
      ARB_RETRY  <= 1'b0;
      XFER_ABORT <= 1'b0;
      if (ARB_WON || ignm_r) begin
        loss_r <= 5'h00;
      end else if (ARB_LOST) begin
        if (limit) begin
          loss_r     <= 5'h00;
          XFER_ABORT <= 1'b1;
        end else begin
          loss_r    <= loss_r + 5'h01;
          ARB_RETRY <= 1'b1;
        end
      end
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arbf_r <= 1'b0;
      csf_r  <= 1'b0;
    end else begin
      arbf_r <= (ARB_LOST && limit && !ARB_WON && !ignm_r) ||
                (arbf_r && !(wr_stat && PWDATA[SMC_ARBF_BIT]));
      csf_r  <= (CS_CHECK && CS_BAD && !skipcs_r) ||
                (csf_r && !(wr_stat && PWDATA[SMC_CSF_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time-out gate
  always_ff @(posedge CLOCK) begin
    if (RST)
      TIMEOUT_EVT <= 1'b0;
    else
      TIMEOUT_EVT <= TIMEOUT_RAW && !toinh_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence lose_s;
    ARB_LOST && !ARB_WON && !ignm_r;
  endsequence

  abort_limit_a: assert property (@(posedge CLOCK) disable iff (RST)
    (lose_s and limit) |=> (XFER_ABORT && arbf_r && loss_r == 5'h00))
    else $error("no abort after sixteenth loss");

  ignore_mast_a: assert property (@(posedge CLOCK) disable iff (RST)
    ignm_r |=> (!XFER_ABORT && !ARB_RETRY))
    else $error("arbitration acted while ignoring masters");

  retry_loss_a: assert property (@(posedge CLOCK) disable iff (RST)
    (lose_s and !limit) |=> (ARB_RETRY && !XFER_ABORT))
    else $error("missing retry after loss");

  skip_cs_a: assert property (@(posedge CLOCK) disable iff (RST)
    (skipcs_r && !csf_r) |=> !csf_r)
    else $error("checksum flag set while skipped");

  cs_flag_a: assert property (@(posedge CLOCK) disable iff (RST)
    (CS_CHECK && CS_BAD && !skipcs_r) |=> csf_r)
    else $error("checksum flag not set");

  timeout_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
    (TIMEOUT_RAW && toinh_r) |=> !TIMEOUT_EVT)
    else $error("time-out reported while inhibited");

  div_reset_a: assert property (@(posedge CLOCK)
    RST |=> (div_r == SMC_DIV_RST))
    else $error("divider reset value wrong");

  fs_legal_a: assert property (@(posedge CLOCK) disable iff (RST)
    (tfs_r != 2'h3) && (cfs_r != 2'h3))
    else $error("reserved filter selection stored");

  apb_ready_a: assert property (@(posedge CLOCK) disable iff (RST)
    (PSEL && !PENABLE) |=> PREADY)
    else $error("apb access not answered in one cycle");

  div_write_a: assert property (@(posedge CLOCK) disable iff (RST)
    wr_ctrl |=> (div_r == $past(div_in)))
    else $error("divider write not stored");

  tfs_none_a: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_ctrl && tfs_in == SMC_FS_NONE) |=> (tfs_r == SMC_FS_NONE))
    else $error("target no-delay selection not stored");

  tfs_rsvd_a: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_ctrl && tfs_in == 2'h3) |=> (tfs_r == SMC_FS_NORMAL))
    else $error("target reserved selection not folded to normal");

  cfs_none_a: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_ctrl && cfs_in == SMC_FS_NONE) |=> (cfs_r == SMC_FS_NONE))
    else $error("controller no-delay selection not stored");

  cfs_rsvd_a: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_ctrl && cfs_in == 2'h3) |=> (cfs_r == SMC_FS_NORMAL))
    else $error("controller reserved selection not folded to normal");

  timeout_pass_a: assert property (@(posedge CLOCK) disable iff (RST)
    (TIMEOUT_RAW && !toinh_r) |=> TIMEOUT_EVT)
    else $error("time-out lost while enabled");

  timeout_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
    !TIMEOUT_RAW |=> !TIMEOUT_EVT)
    else $error("time-out reported without cause");

  won_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    ARB_WON |=> (loss_r == 5'h00 && !ARB_RETRY && !XFER_ABORT))
    else $error("won arbitration did not clear the loss count");

  ignore_count_a: assert property (@(posedge CLOCK) disable iff (RST)
    ignm_r |=> (loss_r == 5'h00))
    else $error("losses counted while ignoring masters");

  arb_sticky_a: assert property (@(posedge CLOCK) disable iff (RST)
    (arbf_r && !wr_stat) |=> arbf_r)
    else $error("arbitration flag dropped without a clear");

  cs_sticky_a: assert property (@(posedge CLOCK) disable iff (RST)
    (csf_r && !wr_stat) |=> csf_r)
    else $error("checksum flag dropped without a clear");

  arb_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    (arbf_r && wr_stat && PWDATA[SMC_ARBF_BIT] && !(ARB_LOST && limit)) |=> !arbf_r)
    else $error("arbitration flag not cleared");

  cs_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
    (csf_r && wr_stat && PWDATA[SMC_CSF_BIT] && !CS_CHECK) |=> !csf_r)
    else $error("checksum flag not cleared");

  apb_err_a: assert property (@(posedge CLOCK) disable iff (RST)
    PSLVERR |-> PREADY)
    else $error("apb error without ready");

endmodule : smc_ctrl

// ===== hw/smc_glitch.sv
// smc_glitch: one-line glitch filter with selectable settle time
// assumes the line is already synchronous to the clock
module smc_glitch #(
  parameter int NORM_CYC = 40,
  parameter int FAST_CYC = 4
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // selection and line
  input  wire logic [1:0] sel,
  input  wire logic       din,
  output logic            dout
);
  import smc_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] lim;

  always_comb begin
    case (sel)
      SMC_FS_NORMAL: lim = 8'(NORM_CYC);
      SMC_FS_FAST:   lim = 8'(FAST_CYC);
      default:       lim = 8'h00;
    endcase
  end

  // new level accepted only after it has stood for lim cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
      dout  <= 1'b1;
    end else if (din == dout) begin
      cnt_r <= 8'h00;
    end else if (cnt_r + 8'h01 >= lim) begin
      cnt_r <= 8'h00;
      dout  <= din;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // a fresh difference never passes on its first cycle in normal mode
  stable_a: assert property (@(posedge clk) disable iff (rst)
    (sel == SMC_FS_NORMAL && din != dout && cnt_r == 8'h00) |=> $stable(dout))
    else $error("filter passed a change too early");

endmodule : smc_glitch

// ===== hw/smc_pkg.sv
// smc_pkg: register map, field layout, reset values and timing counts
// assumes a 40 MHz core clock and an APB register slave
package smc_pkg;

  // register map
  localparam logic [11:0] SMC_CTRL_ADDR   = 12'h428;
  localparam logic [11:0] SMC_STAT_ADDR   = 12'h424;

  // control and status field positions
  localparam int          SMC_DIV_LSB     = 0;
  localparam int          SMC_DIV_W       = 16;
  localparam int          SMC_IGNM_BIT    = 16;
  localparam int          SMC_SKIPCS_BIT  = 17;
  localparam int          SMC_TFS_LSB     = 18;
  localparam int          SMC_CFS_LSB     = 20;
  localparam int          SMC_TOINH_BIT   = 22;
  localparam int          SMC_ARBF_BIT    = 26;
  localparam int          SMC_CSF_BIT     = 28;

  // reset values
  localparam logic [15:0] SMC_DIV_RST     = 16'h0053;
  localparam logic [1:0]  SMC_FS_RST      = 2'h0;

  // filter selections
  localparam logic [1:0]  SMC_FS_NORMAL   = 2'h0;
  localparam logic [1:0]  SMC_FS_FAST     = 2'h1;
  localparam logic [1:0]  SMC_FS_NONE     = 2'h2;

  // timing: prescaler unit and glitch wait
  localparam int          SMC_CLK_MHZ     = 40;
  localparam int          SMC_UNIT_NS     = 32;
  localparam int          SMC_GLITCH_NS   = 1000;
  localparam int          SMC_UNIT_CYC    = (SMC_UNIT_NS * SMC_CLK_MHZ + 999) / 1000;
  localparam int          SMC_GLITCH_CYC  = (SMC_GLITCH_NS * SMC_CLK_MHZ) / 1000;
  localparam int          SMC_FAST_CYC    = 4;

  // arbitration retry limit
  localparam int          SMC_ARB_LIMIT   = 16;

endpackage : smc_pkg

// ===== hw/smc_prescale.sv
// smc_prescale: controller-port prescaler tick and clock generator
// assumes the divider may be rewritten at any time
module smc_prescale #(
  parameter int UNIT_CYC = 2
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // divider setting
  input  wire logic [15:0] div,
  // outputs
  output logic             tick,
  output logic             pclk
);
  import smc_pkg::*;

  logic [7:0]  unit_r;
  logic [15:0] cnt_r;
  logic        run;
  logic        ustep;
  logic [15:0] half;

  assign run   = (div > 16'h0001);
  assign half  = (div >> 1) + {15'h0000, div[0]};
  assign ustep = (unit_r == 8'(UNIT_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      unit_r <= 8'h00;
      cnt_r  <= 16'h0000;
      tick   <= 1'b0;
      pclk   <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (ustep) begin
        unit_r <= 8'h00;
        // >= so a lowered divider does not run the count round the full range
        if (cnt_r >= div - 16'h0001) begin
          cnt_r <= 16'h0000;
          tick  <= 1'b1;
          pclk  <= 1'b0;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 == half)
            pclk <= 1'b1;   // low half, rounded up, keeps minimum low time
        end
      end else begin
        unit_r <= unit_r + 8'h01;
      end
    end
  end

  stopped_a: assert property (@(posedge clk) disable iff (rst)
    (div <= 16'h0001) |=> (!tick && !pclk))
    else $error("prescaler runs with divider below two");

endmodule : smc_prescale
